// ---- inc/hspp_pkg.sv ----
// Purpose: Shared constants for the handshake parallel port
// Assumes: AXI4-Lite register access, 32-bit data, one register per word
// Notes:   Printed offsets are not all multiples of four, so each is an index
package hspp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL   = 16'h1002;
  localparam logic [15:0] IDX_PIN_LEVEL = 16'h1003;
  localparam logic [15:0] IDX_LATCHED   = 16'h1005;
  localparam logic [15:0] IDX_DIRECTION = 16'h1007;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'h1010;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'h1011;
  localparam int          ADDR_W        = 18;
  // Control bit positions
  localparam int BIT_FLAG      = 7;
  localparam int BIT_OPEN_DRN  = 6;
  localparam int BIT_IRQ_EN    = 5;
  localparam int BIT_HANDSHAKE = 4;
  localparam int BIT_OUT_HS    = 3;
  localparam int BIT_PULSE     = 2;
  localparam int BIT_EDGE      = 1;
  localparam int BIT_INVERT    = 0;
  // Interrupt status bit positions
  localparam int BIT_IS_STROBE = 0;
  localparam int BIT_IS_FLAGIRQ = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET    = 8'h00;
  localparam logic [7:0] DIR_RESET     = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Ready pulse length in pulse mode
  localparam int          PULSE_NS     = 10;
  localparam int          CLK_PS       = 5000;
  localparam int          PULSE_CYC    = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [3:0]  PULSE_CNT    = 4'(PULSE_CYC);
endpackage : hspp_pkg

// ---- rtl/hspp_top.sv ----
// Purpose: Handshake parallel port with AXI4-Lite register access
// Assumes: Port pins synchronous to aclk; one clock domain
// Notes:   Pins are split into input, output and output enable
//
// Functional notes
// R1: Input mode: port latches on strobe edge; device drives ready.
// R2: Partner waits for ready, sets data, then pulses strobe.
// R3: Strobe edge in input mode latches data, sets flag, drops ready.
// R4: Reading latched register reasserts ready, flag untouched.
// R5: Partner never strobes while ready is deasserted.
// R6: Pulse select: ready is a pulse or an interlocked level.
// R7: Handshake leaves static input and output lines alone. Output mode without the three-state variant drives all lines.
// R8: Pin level register reads the live pins on input lines.
// R9: Writes to either data register update one output register.
// R10: Software should clear direction bits of latched input lines.
// R11: Output mode: port drives, ready means data, strobe acknowledges.
// R12: Partner takes the byte then pulses strobe as acknowledge.
// R13: Acknowledge edge drops ready and sets the flag.
// R14: Writing latched register in output mode drives data, raises ready.
// R15: Three-state variant: strobe inactive, lines follow direction bits.
// R16: Three-state variant: strobe active forces all lines to outputs.
// R17: Control register holds flag, open drain, irq enable, mode bits.
// R18: Edge select picks strobe edge; invert picks ready level.
// R19: Flag with irq enable set holds an interrupt until cleared.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module hspp_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_in,
  output logic [7:0]       port_out,
  output logic [7:0]       port_oe,
  input  wire logic        strobe_ack_in,
  input  wire logic        three_state_enable,
  output logic             ready_out,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  control_reg;
  logic [7:0]  out_reg;
  logic [7:0]  direction_reg;
  logic [7:0]  latched_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic        ready_reg;
  logic [3:0]  pulse_reg;
  logic        strobe_d_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        strobe_edge;
  logic        wr_ctl;
  logic        wr_lat;
  logic        wr_pin;
  logic        rd_lat;
  logic        hs_on;
  logic        out_mode;
  logic        strobe_active;
  logic        flag_irq;

  // Word index compare uses the package width
  localparam int ADDR_W = hspp_pkg::ADDR_W;

  function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
    hit = (addr[ADDR_W-1:2] == idx) && (addr[31:ADDR_W] == '0) && (addr[1:0] == 2'h0);
  endfunction : hit

  assign hs_on    = control_reg[hspp_pkg::BIT_HANDSHAKE];
  assign out_mode = control_reg[hspp_pkg::BIT_OUT_HS];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 32'h0000_0000;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hspp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit(awaddr_reg, hspp_pkg::IDX_CONTROL)
                      || hit(awaddr_reg, hspp_pkg::IDX_PIN_LEVEL)
                      || hit(awaddr_reg, hspp_pkg::IDX_LATCHED)
                      || hit(awaddr_reg, hspp_pkg::IDX_DIRECTION)
                      || hit(awaddr_reg, hspp_pkg::IDX_IRQ_STAT)
                      || hit(awaddr_reg, hspp_pkg::IDX_IRQ_MASK))
                      ? hspp_pkg::RESP_OKAY : hspp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register data
  assign wr_ctl = wr_fire && wstrb_reg[0] && hit(awaddr_reg, hspp_pkg::IDX_CONTROL);
  assign wr_pin = wr_fire && wstrb_reg[0] && hit(awaddr_reg, hspp_pkg::IDX_PIN_LEVEL);
  assign wr_lat = wr_fire && wstrb_reg[0] && hit(awaddr_reg, hspp_pkg::IDX_LATCHED);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_lat        = rd_fire && hit(s_axi_araddr, hspp_pkg::IDX_LATCHED);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= hspp_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= hspp_pkg::RESP_OKAY;
      if (hit(s_axi_araddr, hspp_pkg::IDX_CONTROL)) begin
        s_axi_rdata <= {24'h000000, control_reg};
      end else if (hit(s_axi_araddr, hspp_pkg::IDX_PIN_LEVEL)) begin
        // R8 live pin levels
        s_axi_rdata <= {24'h000000, (port_in & ~port_oe) | (out_reg & port_oe)};
      end else if (hit(s_axi_araddr, hspp_pkg::IDX_LATCHED)) begin
        s_axi_rdata <= {24'h000000, latched_reg};
      end else if (hit(s_axi_araddr, hspp_pkg::IDX_DIRECTION)) begin
        s_axi_rdata <= {24'h000000, direction_reg};
      end else if (hit(s_axi_araddr, hspp_pkg::IDX_IRQ_STAT)) begin
        s_axi_rdata <= {30'h0000000, irq_stat_reg};
      end else if (hit(s_axi_araddr, hspp_pkg::IDX_IRQ_MASK)) begin
        s_axi_rdata <= {30'h0000000, irq_mask_reg};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= hspp_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R18 strobe edge select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_ack_in;
    end
  end
  assign strobe_edge = control_reg[hspp_pkg::BIT_EDGE] ? (strobe_ack_in && !strobe_d_reg)
                                                       : (!strobe_ack_in && strobe_d_reg);
  assign strobe_active = control_reg[hspp_pkg::BIT_EDGE] ? strobe_ack_in : !strobe_ack_in;

  ////////////////////////////////////////////////////////////////////////////
  // R17 control register; flag bit is hardware set only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= hspp_pkg::CONTROL_RESET;
    end else begin
      if (wr_ctl) begin
        control_reg[6:0] <= wdata_reg[6:0];
      end
      // R3 flag set on strobe edge
      // R13 acknowledge sets flag
      if (hs_on && strobe_edge) begin
        control_reg[hspp_pkg::BIT_FLAG] <= 1'b1;
      end else if (wr_ctl && wdata_reg[hspp_pkg::BIT_FLAG]) begin
        control_reg[hspp_pkg::BIT_FLAG] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R9 shared output register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg       <= hspp_pkg::PORT_RESET;
      direction_reg <= hspp_pkg::DIR_RESET;
    end else begin
      if (wr_pin || wr_lat) begin
        out_reg <= wdata_reg[7:0];
      end
      if (wr_fire && wstrb_reg[0] && hit(awaddr_reg, hspp_pkg::IDX_DIRECTION)) begin
        direction_reg <= wdata_reg[7:0];
      end
    end
  end

  // R3 latch on input strobe edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_reg <= hspp_pkg::PORT_RESET;
    end else if (hs_on && !out_mode && strobe_edge) begin
      latched_reg <= port_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R1 ready driven by device
  // R4 latched read asserts ready
  // R14 latched write asserts ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_reg <= 1'b0;
      pulse_reg <= 4'h0;
    end else begin
      if (hs_on && strobe_edge) begin
        ready_reg <= 1'b0;
        pulse_reg <= 4'h0;
      end else if (hs_on && ((!out_mode && rd_lat) || (out_mode && wr_lat))) begin
        ready_reg <= 1'b1;
        pulse_reg <= hspp_pkg::PULSE_CNT;
      end else if (control_reg[hspp_pkg::BIT_PULSE] && ready_reg) begin
        // R6 pulse mode ends after a fixed count
        pulse_reg <= pulse_reg - 4'h1;
        if (pulse_reg <= 4'h1) begin
          ready_reg <= 1'b0;
        end
      end
    end
  end
  // R18 ready polarity
  assign ready_out = ready_reg ^ control_reg[hspp_pkg::BIT_INVERT];

  ////////////////////////////////////////////////////////////////////////////
  // R11 output mode drives port
  // R7 static lines follow direction except in output mode without three-state or with strobe active
  // R15 inactive strobe obeys direction
  // R16 active strobe forces outputs
  always_comb begin
    port_oe = direction_reg;
    if (hs_on && out_mode && three_state_enable && strobe_active) begin
      port_oe = 8'hFF;
    end else if (hs_on && out_mode && !three_state_enable) begin
      port_oe = 8'hFF;
    end
    // Open drain lines drive only low
    if (control_reg[hspp_pkg::BIT_OPEN_DRN]) begin
      port_oe = port_oe & ~out_reg;
    end
  end
  assign port_out = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-clear
  assign flag_irq = control_reg[hspp_pkg::BIT_FLAG] && control_reg[hspp_pkg::BIT_IRQ_EN];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= hspp_pkg::IRQ_RESET;
      irq_mask_reg <= hspp_pkg::IRQ_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == hspp_pkg::BIT_IS_STROBE) ? (hs_on && strobe_edge) : flag_irq) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_fire && wstrb_reg[0] && hit(awaddr_reg, hspp_pkg::IDX_IRQ_STAT)
                     && wdata_reg[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      if (wr_fire && wstrb_reg[0] && hit(awaddr_reg, hspp_pkg::IDX_IRQ_MASK)) begin
        irq_mask_reg <= wdata_reg[1:0];
      end
    end
  end
  // R19 request held with flag and enable
  assign irq = |(irq_stat_reg & irq_mask_reg) || flag_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    hs_on && strobe_edge |=> control_reg[hspp_pkg::BIT_FLAG])
    else $error("flag not set on strobe edge");
  ready_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    hs_on && strobe_edge |=> !ready_reg)
    else $error("ready not dropped on strobe edge");
  latch_cap_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    hs_on && !out_mode && strobe_edge |=> latched_reg == $past(port_in))
    else $error("latched data wrong");
  ready_rd_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    hs_on && !out_mode && rd_lat && !strobe_edge |=> ready_reg)
    else $error("ready not raised by latched read");
  ready_wr_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    hs_on && out_mode && wr_lat && !strobe_edge |=> ready_reg && port_out == $past(wdata_reg[7:0]))
    else $error("ready or data wrong after latched write");
  out_share_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    wr_pin |=> out_reg == $past(wdata_reg[7:0]) && ready_reg == $past(ready_reg))
    else $error("shared output register wrong");
  force_oe_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    hs_on && out_mode && three_state_enable && strobe_active
      && !control_reg[hspp_pkg::BIT_OPEN_DRN] |-> port_oe == 8'hFF)
    else $error("lines not forced to outputs");
  dir_oe_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    !(hs_on && out_mode) && !control_reg[hspp_pkg::BIT_OPEN_DRN] |-> port_oe == direction_reg)
    else $error("lines do not follow direction");
  pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    control_reg[hspp_pkg::BIT_PULSE] && $rose(ready_reg) && !(hs_on && strobe_edge)
      ##1 !(hs_on && strobe_edge) |=> !ready_reg)
    else $error("ready pulse too long");
  irq_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    flag_irq |-> irq)
    else $error("interrupt not requested");
  in_hs_c: cover property (@(posedge aclk) disable iff (!aresetn)
    hs_on && !out_mode && strobe_edge ##[1:20] rd_lat);
  out_hs_c: cover property (@(posedge aclk) disable iff (!aresetn)
    hs_on && out_mode && wr_lat ##[1:20] strobe_edge);
  irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  pulse_c: cover property (@(posedge aclk) disable iff (!aresetn)
    control_reg[hspp_pkg::BIT_PULSE] && $rose(ready_reg));
  tri_c: cover property (@(posedge aclk) disable iff (!aresetn)
    hs_on && out_mode && three_state_enable && strobe_active);

  // Status, read, write and edge checks
  sts_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    hs_on && strobe_edge |=> irq_stat_reg[hspp_pkg::BIT_IS_STROBE])
    else $error("strobe status not set");
  irq_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    flag_irq |=> irq_stat_reg[hspp_pkg::BIT_IS_FLAGIRQ])
    else $error("flag interrupt status not set");
  flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    rd_lat && !(hs_on && strobe_edge) && !wr_ctl
      |=> control_reg[hspp_pkg::BIT_FLAG] == $past(control_reg[hspp_pkg::BIT_FLAG]))
    else $error("latched read changed the flag");
  pin_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    rd_fire && hit(s_axi_araddr, hspp_pkg::IDX_PIN_LEVEL)
      |=> (s_axi_rdata[7:0] & ~$past(port_oe)) == ($past(port_in) & ~$past(port_oe)))
    else $error("pin read not live on input lines");
  in_ready_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    hs_on && !out_mode && (wr_lat || wr_pin) && !rd_lat && !strobe_edge
      && !control_reg[hspp_pkg::BIT_PULSE] |=> ready_reg == $past(ready_reg))
    else $error("data write moved ready");
  out_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    !wr_pin && !wr_lat |=> out_reg == $past(out_reg))
    else $error("output register changed without a write");
  edge_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    hs_on && strobe_edge |-> strobe_ack_in != $past(strobe_ack_in)
      && strobe_ack_in == control_reg[hspp_pkg::BIT_EDGE])
    else $error("strobe edge of wrong sense");

endmodule : hspp_top

// ---- tb/hspp_ext_dev.sv ----
// Purpose: External device on the strobe handshake, source and sink
// Assumes: Ready active high when used by send and take
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module hspp_ext_dev (
  input  wire logic       aclk,
  input  wire logic [7:0] port_out,
  input  wire logic       ready_out,
  output logic      [7:0] port_in,
  output logic            strobe_ack_in
);
  logic [7:0] got;
  initial begin
    port_in       = 8'h00;
    strobe_ack_in = 1'b0;
    got           = 8'h00;
  end
  task automatic level(input logic v);
    @(posedge aclk);
    strobe_ack_in <= v;
  endtask : level
  task automatic pulse();
    level(1'b1);
    repeat (2) @(posedge aclk);
    strobe_ack_in <= 1'b0;
  endtask : pulse
  task automatic send(input logic [7:0] b);
    do @(posedge aclk); while (ready_out !== 1'b1);
    port_in <= b;
    pulse();
    @(posedge aclk);
    // Hold time over, old byte must not linger
    port_in <= ~b;
  endtask : send
  task automatic take();
    do @(posedge aclk); while (ready_out !== 1'b1);
    got = port_out;
    pulse();
  endtask : take
endmodule : hspp_ext_dev

// ---- tb/hspp_top_tb.sv ----
// Purpose: Self-checking bench for the handshake parallel port
// Assumes: Register byte address is four times the index
// Notes:   Table rows first, handshake cases by hand after
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module hspp_top_tb;
  typedef struct packed {logic [31:0] a; logic [31:0] d;
                         logic [31:0] e; logic [1:0] r;} hspp_row_t;
  localparam logic [31:0] A_CTL = 32'h00004008;
  localparam logic [31:0] A_PIN = 32'h0000400C;
  localparam logic [31:0] A_LAT = 32'h00004014;
  localparam logic [31:0] A_DIR = 32'h0000401C;
  localparam logic [31:0] A_STS = 32'h00004040;
  localparam logic [31:0] A_MSK = 32'h00004044;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, strobe, tse, ready, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  logic [7:0]  port_in, port_out, port_oe;
  int          err_total, checks_done, hi_cnt;
  hspp_row_t   rows [6];
  hspp_top u_hspp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .strobe_ack_in(strobe),
    .three_state_enable(tse), .ready_out(ready), .irq(irq));
  hspp_ext_dev u_hspp_ext_dev (.aclk(aclk), .port_out(port_out), .ready_out(ready),
    .port_in(port_in), .strobe_ack_in(strobe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rdr
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Pulse length seen on ready, sampled mid-cycle
  always @(negedge aclk) if (ready === 1'b1) hi_cnt++;
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    wrap_up();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tse} = '0;
    wstrb = 4'hF;
    {awaddr, wdata, araddr} = '0;
    aresetn = 1'b0;
    err_total = 0;
    checks_done = 0;
    rows = '{'{A_DIR, 32'hA5, 32'hA5, 2'h0}, '{A_MSK, 32'h3, 32'h3, 2'h0},
             '{A_CTL, 32'h66, 32'h66, 2'h0}, '{A_CTL, 32'hA6, 32'h26, 2'h0},
             '{32'h00004000, 32'h12, 32'h0, 2'h2}, '{A_DIR, 32'h0, 32'h0, 2'h0}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK({ready, irq, port_oe}, 10'h000)
    foreach (rows[i]) begin
      rdr(rows[i].a);
      `CHK(rd, 32'h0)
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK(rs, rows[i].r)
      rdr(rows[i].a);
      `CHK({rd, rs}, {rows[i].e, rows[i].r})
    end
    // Lane 0 strobe low: write ignored but answered OKAY
    wstrb <= 4'h0;
    wr(A_DIR, 32'hFF);
    `CHK(rs, hspp_pkg::RESP_OKAY)
    wstrb <= 4'hF;
    rdr(A_DIR);
    `CHK(rd, 32'h0)
    $display("Test registers done");
    // Upper lines latched inputs, lower lines static outputs
    wr(A_DIR, 32'h0F);
    wr(A_PIN, 32'h05);
    wr(A_MSK, 32'h1);
    wr(A_CTL, 32'h32);
    rdr(A_LAT);
    @(negedge aclk);
    `CHK(ready, 1'b1)
    u_hspp_ext_dev.send(8'hA5);
    @(negedge aclk);
    `CHK({ready, irq}, 2'b01)
    `CHK({port_out, port_oe}, 16'h050F)
    rdr(A_CTL);
    `CHK(rd, 32'hB2)
    wr(A_LAT, 32'h0A);
    @(negedge aclk);
    `CHK({port_out, ready}, 9'h014)
    rdr(A_PIN);
    `CHK(rd, 32'h5A)
    rdr(A_LAT);
    @(negedge aclk);
    `CHK({rd[7:0], ready, irq}, 10'h297)
    wr(A_CTL, 32'hB2);
    wr(A_STS, 32'h3);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    $display("Test input handshake done");
    u_hspp_ext_dev.send(8'h3C);
    wr(A_CTL, 32'h96);
    hi_cnt = 0;
    rdr(A_LAT);
    repeat (8) @(negedge aclk);
    `CHK(hi_cnt, hspp_pkg::PULSE_CYC)
    `CHK(rd, 32'h3C)
    $display("Test pulse mode done");
    wr(A_CTL, 32'h1A);
    wr(A_LAT, 32'hC3);
    @(negedge aclk);
    `CHK({port_out, ready, port_oe}, 17'h187FF)
    u_hspp_ext_dev.take();
    @(negedge aclk);
    `CHK({u_hspp_ext_dev.got, ready}, 9'h186)
    rdr(A_CTL);
    `CHK(rd, 32'h9A)
    $display("Test output handshake done");
    @(posedge aclk);
    tse <= 1'b1;
    @(negedge aclk);
    `CHK(port_oe, 8'h0F)
    u_hspp_ext_dev.level(1'b1);
    @(negedge aclk);
    `CHK(port_oe, 8'hFF)
    u_hspp_ext_dev.level(1'b0);
    $display("Test three-state done");
    // Falling edge, inverted ready
    wr(A_CTL, 32'h99);
    @(negedge aclk);
    `CHK(ready, 1'b1)
    wr(A_LAT, 32'h11);
    u_hspp_ext_dev.level(1'b1);
    repeat (3) @(negedge aclk);
    `CHK(ready, 1'b0)
    u_hspp_ext_dev.level(1'b0);
    repeat (3) @(negedge aclk);
    `CHK(ready, 1'b1)
    $display("Test edge and polarity done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK({ready, irq, port_oe, port_out}, 18'h00000)
    $display("Test reset done");
    wrap_up();
  end
endmodule : hspp_top_tb
